// ==== verilog/hmlu_load_unit.sv ====
// Purpose: decode and execute halfword zero loads and the multiple-word load
// Assumes: one memory read outstanding; general registers live outside
// Notes: one request per instruction for halfwords, one per word for multiple
`timescale 1ns/1ps
module hmlu_load_unit #(
	parameter int unsigned xlen = hmlu_pkg::hmlu_xlen
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire logic [31:0] instr_word,
	output logic instr_ready,
	output logic instr_illegal,
	output logic [4:0] rf_read_a_sel,
	output logic [4:0] rf_read_b_sel,
	input wire logic [xlen-1:0] rf_read_a_data,
	input wire logic [xlen-1:0] rf_read_b_data,
	input wire logic msr_user_mode,
	input wire logic msr_data_reloc,
	output logic mem_req,
	output logic [xlen-1:0] mem_addr,
	output logic mem_half,
	input wire logic mem_ack,
	input wire logic [xlen-1:0] mem_rdata,
	input wire logic mem_tlb_hit,
	input wire logic mem_zone_no_access,
	output logic rf_write_en,
	output logic [4:0] rf_write_sel,
	output logic [xlen-1:0] rf_write_data,
	output logic exc_data_storage,
	output logic exc_data_tlb_miss,
	output logic [xlen-1:0] exc_addr,
	output logic busy
);
	typedef enum logic [3:0] {
		hmlu_idle_s = 4'h1,
		hmlu_read_s = 4'h2,
		hmlu_update_s = 4'h4,
		hmlu_multi_s = 4'h8
	} hmlu_state_t;

	hmlu_state_t state;
	logic [5:0] opcd;
	logic [9:0] xo;
	logic [4:0] fld_t;
	logic [4:0] fld_a;
	logic [4:0] fld_b;
	logic reserved_bit;
	logic is_dz, is_dzu, is_lmw, is_brx, is_xzu, is_xz;
	logic is_update, is_indexed, known;
	logic [xlen-1:0] base, offs, effective_address;
	logic [xlen-1:0] cur_addr;
	logic [4:0] cur_reg, tgt_reg, upd_reg;
	logic [4:0] multi_base;
	logic reversed;
	logic is_update_hold;
	logic fault_storage, fault_miss;

	// sign-extend a displacement field
	function automatic logic [xlen-1:0] hmlu_sext(input logic [15:0] d);
		hmlu_sext = {{(xlen - hmlu_pkg::hmlu_disp_width){d[15]}}, d};
	endfunction

	// halfword placement: normal puts low address byte high
	function automatic logic [xlen-1:0] hmlu_half(input logic [15:0] h, input logic rev);
		if (rev)
			hmlu_half = {{(xlen - hmlu_pkg::hmlu_disp_width){1'b0}}, h[7:0], h[15:8]};
		else
			hmlu_half = {{(xlen - hmlu_pkg::hmlu_disp_width){1'b0}}, h};
	endfunction

	// field extraction
	assign opcd = instr_word[hmlu_pkg::hmlu_opcd_lsb +: 6];
	assign xo = instr_word[hmlu_pkg::hmlu_xo_lsb +: 10];
	assign fld_t = instr_word[hmlu_pkg::hmlu_target_lsb +: 5];
	assign fld_a = instr_word[hmlu_pkg::hmlu_base_lsb +: 5];
	assign fld_b = instr_word[hmlu_pkg::hmlu_index_lsb +: 5];
	assign reserved_bit = instr_word[0];

	// opcode decode
	assign is_dz = (opcd == hmlu_pkg::hmlu_op_half_zero);
	assign is_dzu = (opcd == hmlu_pkg::hmlu_op_half_zero_update);
	assign is_lmw = (opcd == hmlu_pkg::hmlu_op_multiple);
	assign is_brx = (opcd == hmlu_pkg::hmlu_op_extended)
		&& (xo == hmlu_pkg::hmlu_xo_half_reverse);
	assign is_xzu = (opcd == hmlu_pkg::hmlu_op_extended)
		&& (xo == hmlu_pkg::hmlu_xo_half_zero_index_update);
	assign is_xz = (opcd == hmlu_pkg::hmlu_op_extended)
		&& (xo == hmlu_pkg::hmlu_xo_half_zero_index);
	assign is_update = is_dzu || is_xzu;
	assign is_indexed = is_brx || is_xzu || is_xz;
	assign known = is_dz || is_dzu || is_lmw || is_indexed;
	// reserved bit and bad update fields are tolerated, not trapped
	assign instr_illegal = instr_valid && !known;

	// register reads and address formation
	assign rf_read_a_sel = fld_a;
	assign rf_read_b_sel = fld_b;
	assign base = (fld_a == 5'h00 && !is_update) ? '0 : rf_read_a_data;
	assign offs = is_indexed ? rf_read_b_data : hmlu_sext(instr_word[15:0]);
	assign effective_address = base + offs;
	assign instr_ready = (state == hmlu_idle_s);
	assign busy = (state != hmlu_idle_s);

	// translation checks on the current access
	assign fault_storage = msr_user_mode && msr_data_reloc && mem_zone_no_access;
	assign fault_miss = msr_data_reloc && !mem_tlb_hit;

	// sequencing and captured operands
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state <= hmlu_idle_s;
			cur_addr <= '0;
			cur_reg <= 5'h00;
			tgt_reg <= 5'h00;
			upd_reg <= 5'h00;
			multi_base <= 5'h00;
			reversed <= 1'b0;
			mem_half <= 1'b0;
		end
		else
		begin
			case (state)
				hmlu_idle_s:
				begin
					if (instr_valid && known && !is_lmw)
					begin
						state <= hmlu_read_s;
						cur_addr <= effective_address;
						tgt_reg <= fld_t;
						upd_reg <= is_update ? fld_a : 5'h00;
						reversed <= is_brx;
						mem_half <= 1'b1;
					end
					else if (instr_valid && is_lmw)
					begin
						state <= hmlu_multi_s;
						cur_addr <= effective_address;
						cur_reg <= fld_t;
						multi_base <= fld_a;
						mem_half <= 1'b0;
					end
				end
				hmlu_read_s:
				begin
					// a fault aborts even when the answer arrives in the same cycle
					if (fault_storage || fault_miss)
						state <= hmlu_idle_s;
					else if (mem_ack)
						state <= (upd_reg != 5'h00 || is_update_hold) ? hmlu_update_s : hmlu_idle_s;
				end
				hmlu_update_s:
					state <= hmlu_idle_s;
				hmlu_multi_s:
				begin
					if (fault_storage || fault_miss)
						state <= hmlu_idle_s;
					else if (mem_ack)
					begin
						cur_addr <= cur_addr + hmlu_pkg::hmlu_word_step;
						cur_reg <= cur_reg + 5'h01;
						if (cur_reg == hmlu_pkg::hmlu_last_reg)
							state <= hmlu_idle_s;
					end
				end
				default:
					state <= hmlu_idle_s;
			endcase
		end
	end

	// update flag kept so a base field of zero still writes back
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			is_update_hold <= 1'b0;
		else if (state == hmlu_idle_s && instr_valid)
			is_update_hold <= is_update;
	end

	// memory request is live while a read is pending
	assign mem_req = (state == hmlu_read_s) || (state == hmlu_multi_s);
	assign mem_addr = cur_addr;

	// register write port and exception reporting
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rf_write_en <= 1'b0;
			rf_write_sel <= 5'h00;
			rf_write_data <= '0;
			exc_data_storage <= 1'b0;
			exc_data_tlb_miss <= 1'b0;
			exc_addr <= '0;
		end
		else
		begin
			rf_write_en <= 1'b0;
			exc_data_storage <= 1'b0;
			exc_data_tlb_miss <= 1'b0;
			if (mem_req && (fault_storage || fault_miss))
			begin
				exc_data_storage <= fault_storage;
				exc_data_tlb_miss <= !fault_storage && fault_miss;
				exc_addr <= cur_addr;
			end
			else if (state == hmlu_read_s && mem_ack)
			begin
				rf_write_en <= 1'b1;
				rf_write_sel <= tgt_reg;
				rf_write_data <= hmlu_half(mem_rdata[15:0], reversed);
			end
			else if (state == hmlu_update_s)
			begin
				rf_write_en <= 1'b1;
				rf_write_sel <= upd_reg;
				rf_write_data <= cur_addr;
			end
			else if (state == hmlu_multi_s && mem_ack)
			begin
				// base register word dropped unless it is the last register
				rf_write_en <= (cur_reg != multi_base)
					|| (cur_reg == hmlu_pkg::hmlu_last_reg);
				rf_write_sel <= cur_reg;
				rf_write_data <= mem_rdata;
			end
		end
	end

	// checks
	chk_half_zero_top: assert property (@(posedge clk) disable iff (rst)
		(state == hmlu_read_s && mem_ack && !fault_storage && !fault_miss)
		|=> rf_write_en && rf_write_data[31:16] == 16'h0000)
		else $error("halfword load upper bits not cleared");
	chk_reverse_bytes: assert property (@(posedge clk) disable iff (rst)
		(state == hmlu_read_s && mem_ack && reversed && !fault_storage && !fault_miss)
		|=> rf_write_data[7:0] == $past(mem_rdata[15:8]))
		else $error("reversed halfword bytes misplaced");
	chk_update_write: assert property (@(posedge clk) disable iff (rst)
		(state == hmlu_update_s) |=> rf_write_en && rf_write_data == $past(cur_addr))
		else $error("update address not written back");
	chk_no_update_idx: assert property (@(posedge clk) disable iff (rst)
		(state == hmlu_idle_s && instr_valid && is_xz) |-> ##1 (state == hmlu_read_s)
		##1 (!is_update_hold))
		else $error("indexed load marked as update");
	chk_storage_fault: assert property (@(posedge clk) disable iff (rst)
		exc_data_storage |-> $past(msr_user_mode) && $past(msr_data_reloc))
		else $error("storage fault outside user relocated mode");
	chk_tlb_miss: assert property (@(posedge clk) disable iff (rst)
		(mem_req && msr_data_reloc && !mem_tlb_hit && !fault_storage) |=> exc_data_tlb_miss)
		else $error("missing translation not reported");
	chk_multi_step: assert property (@(posedge clk) disable iff (rst)
		(state == hmlu_multi_s && mem_ack && !fault_storage && !fault_miss
		&& cur_reg != hmlu_pkg::hmlu_last_reg)
		|=> cur_addr == $past(cur_addr) + hmlu_pkg::hmlu_word_step)
		else $error("multiple load address step wrong");
	chk_base_discard: assert property (@(posedge clk) disable iff (rst)
		(state == hmlu_multi_s && mem_ack && !fault_storage && !fault_miss
		&& cur_reg == multi_base && cur_reg != hmlu_pkg::hmlu_last_reg)
		|=> !rf_write_en)
		else $error("base register overwritten in multiple load");
	chk_zero_base: assert property (@(posedge clk) disable iff (rst)
		(instr_valid && fld_a == 5'h00 && !is_update && !is_indexed && known && !is_lmw)
		|-> effective_address == hmlu_sext(instr_word[15:0]))
		else $error("zero base field not treated as zero");
	cov_reverse: cover property (@(posedge clk) disable iff (rst)
		state == hmlu_read_s && reversed && mem_ack);
	cov_update: cover property (@(posedge clk) disable iff (rst) state == hmlu_update_s);
	cov_multi_end: cover property (@(posedge clk) disable iff (rst)
		state == hmlu_multi_s && mem_ack && cur_reg == hmlu_pkg::hmlu_last_reg);
	cov_fault: cover property (@(posedge clk) disable iff (rst) exc_data_tlb_miss);
	cov_reserved: cover property (@(posedge clk) disable iff (rst)
		instr_valid && is_indexed && reserved_bit);
endmodule

// ==== verilog/hmlu_pkg.sv ====
// Purpose: shared constants for the halfword and multiple-word load unit
// Assumes: big-endian bit numbering in the instruction word (bit 0 is msb)
// Notes: field positions are given as lsb-based verilog indices
package hmlu_pkg;
	localparam int unsigned hmlu_xlen = 32;
	localparam int unsigned hmlu_rsel = 5;
	// primary opcodes
	localparam logic [5:0] hmlu_op_half_zero = 6'h28;
	localparam logic [5:0] hmlu_op_half_zero_update = 6'h29;
	localparam logic [5:0] hmlu_op_multiple = 6'h2e;
	localparam logic [5:0] hmlu_op_extended = 6'h1f;
	// extended opcodes
	localparam logic [9:0] hmlu_xo_half_reverse = 10'h316;
	localparam logic [9:0] hmlu_xo_half_zero_index_update = 10'h137;
	localparam logic [9:0] hmlu_xo_half_zero_index = 10'h117;
	// instruction field positions
	localparam int unsigned hmlu_opcd_lsb = 26;
	localparam int unsigned hmlu_target_lsb = 21;
	localparam int unsigned hmlu_base_lsb = 16;
	localparam int unsigned hmlu_index_lsb = 11;
	localparam int unsigned hmlu_xo_lsb = 1;
	localparam int unsigned hmlu_disp_width = 16;
	// multiple-word load details
	localparam logic [4:0] hmlu_last_reg = 5'h1f;
	localparam logic [31:0] hmlu_word_step = 32'h0000_0004;
	localparam logic [31:0] hmlu_zero_word = 32'h0000_0000;
endpackage

// ==== verification/hmlu_mem_model.sv ====
// Purpose: data memory model that answers the load unit's reads
// Assumes: the byte at address a holds a[7:0] xor 8'h5a
// Notes: the data bus toggles while no answer is given
`timescale 1ns/1ps
module hmlu_mem_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] ack_delay,
	input wire logic fault_zone,
	input wire logic fault_miss,
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	input wire logic mem_half,
	output logic mem_ack,
	output logic [31:0] mem_rdata,
	output logic mem_tlb_hit,
	output logic mem_zone_no_access
);
	logic [3:0] wait_cnt;
	function automatic logic [7:0] bt(input logic [31:0] a);
		return a[7:0] ^ 8'h5a;
	endfunction
	// fault qualifiers held as levels
	assign mem_tlb_hit = !fault_miss;
	assign mem_zone_no_access = fault_zone;
	// answer after a chosen wait, low address byte on top
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			mem_ack <= 1'b0;
			wait_cnt <= 4'h0;
			mem_rdata <= 32'h0;
		end
		else
		begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			wait_cnt <= 4'h0;
			if (mem_req && !mem_ack && wait_cnt != ack_delay)
				wait_cnt <= wait_cnt + 4'h1;
			if (mem_req && !mem_ack && wait_cnt == ack_delay)
			begin
				mem_ack <= 1'b1;
				mem_rdata <= mem_half ? {16'hffff, bt(mem_addr), bt(mem_addr + 32'h1)}
					: {bt(mem_addr), bt(mem_addr + 32'h1), bt(mem_addr + 32'h2), bt(mem_addr + 32'h3)};
			end
		end
	end
endmodule

// ==== verification/halfword_and_multiple_load_unit_tb.sv ====
// Purpose: self-checking bench for the halfword and multiple-word load unit
// Assumes: register file lives in the bench, memory in its model
// Notes: ordinary loads run from a table, faults and refusals by hand
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module halfword_and_multiple_load_unit_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic instr_valid = 1'b0;
	logic [31:0] instr_word = 32'h0;
	logic msr_user_mode = 1'b0;
	logic msr_data_reloc = 1'b0;
	logic fault_zone = 1'b0;
	logic fault_miss = 1'b0;
	logic [3:0] ack_delay = 4'h0;
	logic [4:0] rf_read_a_sel, rf_read_b_sel, rf_write_sel;
	logic [31:0] rf_read_a_data, rf_read_b_data, mem_addr, mem_rdata, rf_write_data, exc_addr;
	logic instr_ready, instr_illegal, mem_req, mem_half, mem_ack, mem_tlb_hit;
	logic mem_zone_no_access, rf_write_en, exc_data_storage, exc_data_tlb_miss, busy;
	logic [31:0] regs [32];
	logic [4:0] got_sel [$], exp_sel [$];
	logic [31:0] got_dat [$], exp_dat [$];
	logic [3:0] flt [5] = '{4'hb, 4'h9, 4'h5, 4'h4, 4'hf};
	int rows [14][4] = '{'{0,3,4,-2}, '{0,3,0,16}, '{2,5,6,7}, '{4,8,0,9}, '{4,8,10,9},
		'{1,10,11,8}, '{1,2,0,4}, '{1,11,11,8}, '{3,12,13,14}, '{3,15,0,1}, '{5,29,5,4},
		'{5,28,29,-8}, '{5,30,31,0}, '{5,0,0,16}};
	int mismatches = 0;
	int checks = 0;
	int n_ds, n_miss;
	assign rf_read_a_data = regs[rf_read_a_sel];
	assign rf_read_b_data = regs[rf_read_b_sel];
	hmlu_load_unit DUT (.clk(clk), .rst(rst), .instr_valid(instr_valid),
		.instr_word(instr_word), .instr_ready(instr_ready), .instr_illegal(instr_illegal),
		.rf_read_a_sel(rf_read_a_sel), .rf_read_b_sel(rf_read_b_sel),
		.rf_read_a_data(rf_read_a_data), .rf_read_b_data(rf_read_b_data),
		.msr_user_mode(msr_user_mode), .msr_data_reloc(msr_data_reloc), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_half(mem_half), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.mem_tlb_hit(mem_tlb_hit), .mem_zone_no_access(mem_zone_no_access),
		.rf_write_en(rf_write_en), .rf_write_sel(rf_write_sel), .rf_write_data(rf_write_data),
		.exc_data_storage(exc_data_storage), .exc_data_tlb_miss(exc_data_tlb_miss),
		.exc_addr(exc_addr), .busy(busy));
	hmlu_mem_model mem (.clk(clk), .rst(rst), .ack_delay(ack_delay), .fault_zone(fault_zone),
		.fault_miss(fault_miss), .mem_req(mem_req), .mem_addr(mem_addr), .mem_half(mem_half),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_tlb_hit(mem_tlb_hit),
		.mem_zone_no_access(mem_zone_no_access));
	function automatic logic [7:0] bt(input logic [31:0] a);
		return a[7:0] ^ 8'h5a;
	endfunction
	// clock
	initial
	begin
		forever #2 clk = ~clk;
	end
	// record register writes and exception pulses
	always @(posedge clk)
	begin
		if (rf_write_en === 1'b1)
		begin
			got_sel.push_back(rf_write_sel);
			got_dat.push_back(rf_write_data);
			regs[rf_write_sel] <= rf_write_data;
		end
		n_ds += int'(exc_data_storage === 1'b1);
		n_miss += int'(exc_data_tlb_miss === 1'b1);
	end
	task automatic final_report();
		if (mismatches == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one instruction: k 0 lhz-like, 1 update, 2 indexed, 3 indexed update, 4 reversed, 5 multiple
	task automatic run(input int k, input int rd, input int ra, input int x);
		logic [31:0] ea, iw;
		logic [4:0] d, a;
		logic [9:0] xo;
		logic ds, ms;
		int n;
		d = 5'(rd);
		a = 5'(ra);
		ea = ((a == 5'h0 && k != 1 && k != 3) ? 32'h0 : regs[a])
			+ ((k < 2 || k == 5) ? {{16{x[15]}}, x[15:0]} : regs[x[4:0]]);
		xo = k == 2 ? hmlu_pkg::hmlu_xo_half_zero_index : (k == 3 ?
			hmlu_pkg::hmlu_xo_half_zero_index_update : hmlu_pkg::hmlu_xo_half_reverse);
		iw = {hmlu_pkg::hmlu_op_extended, d, a, x[4:0], xo, 1'b0};
		if (k == 0 || k == 1 || k == 5)
			iw = {k == 0 ? hmlu_pkg::hmlu_op_half_zero : (k == 1 ?
				hmlu_pkg::hmlu_op_half_zero_update : hmlu_pkg::hmlu_op_multiple), d, a, x[15:0]};
		exp_sel.delete();
		exp_dat.delete();
		for (int r = rd; r < 32 && k == 5; r++)
			if (r != ra || r == 31)
			begin
				exp_sel.push_back(5'(r));
				exp_dat.push_back({bt(ea + 32'(4 * (r - rd))), bt(ea + 32'(4 * (r - rd) + 1)),
					bt(ea + 32'(4 * (r - rd) + 2)), bt(ea + 32'(4 * (r - rd) + 3))});
			end
		if (k != 5)
		begin
			exp_sel.push_back(d);
			exp_dat.push_back(k == 4 ? {16'h0, bt(ea + 32'h1), bt(ea)} : {16'h0, bt(ea), bt(ea + 32'h1)});
		end
		if (k == 1 || k == 3)
		begin
			exp_sel.push_back(a);
			exp_dat.push_back(ea);
		end
		ds = fault_zone && msr_user_mode && msr_data_reloc;
		ms = !ds && fault_miss && msr_data_reloc;
		if (ds || ms)
			exp_sel.delete();
		got_sel.delete();
		got_dat.delete();
		n_ds = 0;
		n_miss = 0;
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_word <= iw;
		@(posedge clk);
		instr_valid <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end while (busy !== 1'b0 && n < 400);
		repeat (2) @(posedge clk);
		if (n >= 400)
			mismatches++;
		`CHK(got_sel.size(), exp_sel.size())
		for (int i = 0; i < exp_sel.size() && i < got_sel.size(); i++)
		begin
			`CHK(got_sel[i], exp_sel[i])
			`CHK(got_dat[i], exp_dat[i])
		end
		`CHK(n_ds, int'(ds))
		`CHK(n_miss, int'(ms))
		if (ds || ms)
			`CHK(exc_addr, ea)
	endtask
	// main sequence
	initial
	begin
		for (int i = 0; i < 32; i++)
			regs[i] = 32'h0001_0000 + 32'(i) * 32'h10;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		`CHK(rf_write_en, 1'b0)
		`CHK(instr_ready, 1'b1)
		for (int i = 0; i < 14; i++)
		begin
			ack_delay <= i[0] ? 4'h3 : 4'h0;
			run(rows[i][0], rows[i][1], rows[i][2], rows[i][3]);
		end
		foreach (flt[j])
		begin
			{fault_zone, fault_miss, msr_user_mode, msr_data_reloc} <= flt[j];
			@(posedge clk);
			run(0, 3, 4, 8);
		end
		{fault_zone, fault_miss} <= 2'b00;
		instr_valid <= 1'b1;
		instr_word <= 32'ha860_0000;
		@(posedge clk);
		#1;
		`CHK(instr_illegal, 1'b1)
		`CHK(mem_req, 1'b0)
		`CHK(instr_ready, 1'b1)
		@(posedge clk);
		instr_valid <= 1'b0;
		run(4, 8, 0, 9);
		final_report();
	end
	// watchdog
	initial
	begin
		#200000;
		mismatches++;
		final_report();
	end
endmodule
